// File: hw/cmdt_pkg.sv
// Shared constants of the CAN mask, data window and timer register slice.
// Assumes an 8-bit special function register bus on the core clock.
package cmdt_pkg;
	// Register addresses on the special function register bus
	localparam logic [7:0] ADDR_TIMER_PRESCALER = 8'hA1;
	localparam logic [7:0] ADDR_MESSAGE_DATA_WINDOW = 8'hA3;
	localparam logic [7:0] ADDR_TIME_TRIGGER_LOW = 8'hA4;
	localparam logic [7:0] ADDR_TIME_TRIGGER_HIGH = 8'hA5;
	localparam logic [7:0] ADDR_MESSAGE_TIMER_LOW = 8'hAC;
	localparam logic [7:0] ADDR_MESSAGE_TIMER_HIGH = 8'hAD;
	localparam logic [7:0] ADDR_TIME_STAMP_LOW = 8'hAE;
	localparam logic [7:0] ADDR_TIME_STAMP_HIGH = 8'hAF;
	localparam logic [7:0] ADDR_ACCEPTANCE_MASK_FOUR = 8'hC7;

	// Field layout of the fourth acceptance mask register
	localparam int IDENT_MASK_HI = 7;
	localparam int IDENT_MASK_LO = 3;
	localparam int IDENT_MASK_W = IDENT_MASK_HI - IDENT_MASK_LO + 1;
	localparam int REMOTE_MASK_BIT = 2;
	localparam int EXT_MASK_BIT = 0;
	localparam logic [7:0] MASK_FOUR_STORED = 8'hFD;

	// Reset values
	localparam logic [7:0] PRESCALER_RESET = 8'h00;
	localparam logic [15:0] TIMER_RESET = 16'h0000;
	localparam logic [7:0] READ_IDLE = 8'h00;

	// Mailbox and data path geometry
	localparam int PAGE_W = 2;
	localparam int BYTE_W = 3;
	localparam int MAILBOX_SIZE = 32;
	localparam int DATA_W = 8;
	localparam int FIFO_WIDTH = PAGE_W + BYTE_W + DATA_W;
	localparam int FIFO_DEPTH = 8;
endpackage

// File: hw/cmdt_stream_if.sv
// Valid/ready stream carrying received bytes between the slice's modules.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface cmdt_stream_if #(parameter int WIDTH = 8);
	logic valid;
	logic ready;
	logic [WIDTH-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

// File: hw/cmdt_fifo.sv
// Small synchronous FIFO in flip-flops with valid/ready on both sides.
// Assumes one clock and an active-low synchronous reset.
`timescale 1ns/100ps
module cmdt_fifo #(
	parameter int WIDTH = 13,
	parameter int DEPTH = 8
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	cmdt_stream_if.snk fill,
	cmdt_stream_if.src drain
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] DEPTH_C = (AW + 1)'(DEPTH);
	localparam logic [AW-1:0] LAST_C = AW'(DEPTH - 1);

	logic [WIDTH-1:0] store [DEPTH];
	logic [AW-1:0] wr_ptr, next_wr_ptr;
	logic [AW-1:0] rd_ptr, next_rd_ptr;
	logic [AW:0] count, next_count;
	logic push, pop;

	assign fill.ready = (count != DEPTH_C);
	assign drain.valid = (count != '0);
	assign drain.data = store[rd_ptr];
	assign push = fill.valid && fill.ready;
	assign pop = drain.valid && drain.ready;

	always_comb
	begin
		next_wr_ptr = wr_ptr;
		next_rd_ptr = rd_ptr;
		next_count = count;
		if (push)
		begin
			next_wr_ptr = (wr_ptr == LAST_C) ? '0 : wr_ptr + 1'b1;
		end
		if (pop)
		begin
			next_rd_ptr = (rd_ptr == LAST_C) ? '0 : rd_ptr + 1'b1;
		end
		if (push && !pop)
		begin
			next_count = count + 1'b1;
		end
		else if (pop && !push)
		begin
			next_count = count - 1'b1;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end
		else
		begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count <= next_count;
		end
	end

	// Payload needs no reset; only the pointers and the count define what is valid
	always_ff @(posedge clk_i)
	begin
		if (push)
		begin
			store[wr_ptr] <= fill.data;
		end
	end
endmodule

// File: hw/cmdt_regs.sv
// Mask, message data window and timer registers of the CAN controller.
// Assumes the rest of the controller supplies page, index, tags and ticks.
//
// Behaviour
// - A cleared mask bit forces its identifier, remote or extension compare true; set compares.
// - The acceptance mask is applied only to received frames, never during transmission.
// - Mask, mailbox data and time stamp storage are left uninitialised by reset.
// - The data window reads and writes the mailbox byte at the selected page and index.
// - With auto-increment each data access advances the byte pointer 0 to 7 and wraps.
// - An 8-bit read/write prescaler, reset to zero, divides the message timer tick.
// - The 16-bit message timer reads as two read-only bytes, both reset to zero.
// - The 16-bit time stamp reads as two bytes that software cannot write.
// - The 16-bit time trigger timer reads as two read-only bytes cleared by reset.
// - The tag bits and remote tag are compared only where the mask bits enable it.
`timescale 1ns/100ps
module cmdt_regs
	import cmdt_pkg::*;
(
	input wire logic CLK_I,
	input wire logic RST_N_I,
	input wire logic [7:0] SFR_ADDR_I,
	input wire logic SFR_WR_I,
	input wire logic SFR_RD_I,
	input wire logic [7:0] SFR_WDATA_I,
	output logic [7:0] SFR_RDATA_O,
	input wire logic [PAGE_W-1:0] PAGE_I,
	input wire logic [BYTE_W-1:0] INDEX_I,
	input wire logic INDEX_LOAD_I,
	input wire logic AUTOINC_I,
	output logic [BYTE_W-1:0] INDEX_O,
	input wire logic BASE_TICK_I,
	input wire logic STAMP_CAPTURE_I,
	input wire logic TTC_SYNC_I,
	input wire logic RX_CHECK_I,
	input wire logic TX_ACTIVE_I,
	input wire logic [IDENT_MASK_W-1:0] RX_IDENT_I,
	input wire logic RX_REMOTE_I,
	input wire logic RX_EXT_I,
	input wire logic [IDENT_MASK_W-1:0] TAG_IDENT_I,
	input wire logic TAG_REMOTE_I,
	input wire logic TAG_EXT_I,
	output logic RX_MATCH_VALID_O,
	output logic RX_MATCH_O,
	input wire logic RX_BYTE_VALID_I,
	output logic RX_BYTE_READY_O,
	input wire logic [PAGE_W-1:0] RX_BYTE_PAGE_I,
	input wire logic [BYTE_W-1:0] RX_BYTE_INDEX_I,
	input wire logic [DATA_W-1:0] RX_BYTE_I,
	input wire logic [PAGE_W-1:0] TX_BYTE_PAGE_I,
	input wire logic [BYTE_W-1:0] TX_BYTE_INDEX_I,
	output logic [DATA_W-1:0] TX_BYTE_O
);
	logic [7:0] timer_prescaler, next_timer_prescaler;
	logic [7:0] presc_count, next_presc_count;
	logic [15:0] message_timer_value, next_message_timer_value;
	logic [15:0] time_trigger_count, next_time_trigger_count;
	logic [15:0] stamp_value, next_stamp_value;
	logic [7:0] acceptance_mask_four, next_acceptance_mask_four;
	logic [BYTE_W-1:0] byte_index, next_byte_index;
	logic [7:0] rdata, next_rdata;
	logic match_valid, next_match_valid;
	logic match, next_match;
	logic [DATA_W-1:0] tx_byte, next_tx_byte;
	logic [DATA_W-1:0] mailbox_byte [MAILBOX_SIZE];
	logic [PAGE_W+BYTE_W-1:0] cpu_slot;
	logic [PAGE_W+BYTE_W-1:0] rx_slot;
	logic [DATA_W-1:0] rx_data;
	logic window_wr, window_rd, mask_wr, presc_wr;
	logic [IDENT_MASK_W-1:0] identifier_mask_bits;
	logic remote_request_mask, extension_flag_mask;
	logic ident_ok, remote_ok, ext_ok;
	logic drain_take;

	cmdt_stream_if #(.WIDTH(FIFO_WIDTH)) rx_fill ();
	cmdt_stream_if #(.WIDTH(FIFO_WIDTH)) rx_drain ();

	// Decoded bus strobes
	assign window_wr = SFR_WR_I && (SFR_ADDR_I == ADDR_MESSAGE_DATA_WINDOW);
	assign window_rd = SFR_RD_I && (SFR_ADDR_I == ADDR_MESSAGE_DATA_WINDOW);
	assign mask_wr = SFR_WR_I && (SFR_ADDR_I == ADDR_ACCEPTANCE_MASK_FOUR);
	assign presc_wr = SFR_WR_I && (SFR_ADDR_I == ADDR_TIMER_PRESCALER);

	assign cpu_slot = {PAGE_I, byte_index};

	// Received bytes queue up while software owns the mailbox write port
	assign rx_fill.valid = RX_BYTE_VALID_I;
	assign rx_fill.data = {RX_BYTE_PAGE_I, RX_BYTE_INDEX_I, RX_BYTE_I};
	assign RX_BYTE_READY_O = rx_fill.ready;
	assign rx_drain.ready = !window_wr;
	assign drain_take = rx_drain.valid && rx_drain.ready;
	assign rx_slot = rx_drain.data[FIFO_WIDTH-1:DATA_W];
	assign rx_data = rx_drain.data[DATA_W-1:0];

	cmdt_fifo #(
		.WIDTH(FIFO_WIDTH),
		.DEPTH(FIFO_DEPTH)
	) u_rx_fifo (
		.clk_i(CLK_I),
		.rst_n_i(RST_N_I),
		.fill(rx_fill.snk),
		.drain(rx_drain.src)
	);

	// Mailbox storage: software writes win, the queued byte waits until window writes stop
	for (genvar slot = 0; slot < MAILBOX_SIZE; slot++)
	begin : g_mailbox
		logic [DATA_W-1:0] next_entry;
		always_comb
		begin
			next_entry = mailbox_byte[slot];
			if (window_wr && (cpu_slot == (PAGE_W + BYTE_W)'(slot)))
			begin
				next_entry = SFR_WDATA_I;
			end
			else if (drain_take && (rx_slot == (PAGE_W + BYTE_W)'(slot)))
			begin
				next_entry = rx_data;
			end
		end
		always_ff @(posedge CLK_I)
		begin
			mailbox_byte[slot] <= next_entry;
		end
	end

	// Byte pointer of the data window
	always_comb
	begin
		next_byte_index = byte_index;
		if (INDEX_LOAD_I)
		begin
			next_byte_index = INDEX_I;
		end
		else if (AUTOINC_I && (window_wr || window_rd))
		begin
			next_byte_index = byte_index + 1'b1;
		end
	end

	// Mask register; reserved bit 1 is not stored and reads zero
	always_comb
	begin
		next_acceptance_mask_four = acceptance_mask_four;
		if (mask_wr)
		begin
			next_acceptance_mask_four = SFR_WDATA_I & MASK_FOUR_STORED;
		end
	end

	always_ff @(posedge CLK_I)
	begin
		acceptance_mask_four <= next_acceptance_mask_four;
	end

	assign identifier_mask_bits = acceptance_mask_four[IDENT_MASK_HI:IDENT_MASK_LO];
	assign remote_request_mask = acceptance_mask_four[REMOTE_MASK_BIT];
	assign extension_flag_mask = acceptance_mask_four[EXT_MASK_BIT];

	// Acceptance of the low identifier bits, remote and extension flags
	assign ident_ok = ((RX_IDENT_I ^ TAG_IDENT_I) & identifier_mask_bits) == '0;
	assign remote_ok = !remote_request_mask || (RX_REMOTE_I == TAG_REMOTE_I);
	assign ext_ok = !extension_flag_mask || (RX_EXT_I == TAG_EXT_I);

	always_comb
	begin
		next_match_valid = 1'b0;
		next_match = match;
		// Transmit frames never consult the mask
		if (RX_CHECK_I && !TX_ACTIVE_I)
		begin
			next_match_valid = 1'b1;
			next_match = ident_ok && remote_ok && ext_ok;
		end
	end

	// Prescaler and timers
	always_comb
	begin
		next_timer_prescaler = timer_prescaler;
		next_presc_count = presc_count;
		next_message_timer_value = message_timer_value;
		next_time_trigger_count = time_trigger_count;
		if (presc_wr)
		begin
			next_timer_prescaler = SFR_WDATA_I;
		end
		if (BASE_TICK_I)
		begin
			if (presc_count >= timer_prescaler)
			begin
				next_presc_count = 8'h00;
				next_message_timer_value = message_timer_value + 1'b1;
			end
			else
			begin
				next_presc_count = presc_count + 1'b1;
			end
		end
		if (TTC_SYNC_I)
		begin
			next_time_trigger_count = message_timer_value;
		end
	end

	always_comb
	begin
		next_stamp_value = stamp_value;
		if (STAMP_CAPTURE_I)
		begin
			next_stamp_value = message_timer_value;
		end
	end

	always_ff @(posedge CLK_I)
	begin
		stamp_value <= next_stamp_value;
	end

	// Read path; unmapped addresses read zero, timers have no write path
	always_comb
	begin
		next_rdata = rdata;
		if (SFR_RD_I)
		begin
			unique case (SFR_ADDR_I)
				ADDR_TIMER_PRESCALER: next_rdata = timer_prescaler;
				ADDR_MESSAGE_DATA_WINDOW: next_rdata = mailbox_byte[cpu_slot];
				ADDR_TIME_TRIGGER_LOW: next_rdata = time_trigger_count[7:0];
				ADDR_TIME_TRIGGER_HIGH: next_rdata = time_trigger_count[15:8];
				ADDR_MESSAGE_TIMER_LOW: next_rdata = message_timer_value[7:0];
				ADDR_MESSAGE_TIMER_HIGH: next_rdata = message_timer_value[15:8];
				ADDR_TIME_STAMP_LOW: next_rdata = stamp_value[7:0];
				ADDR_TIME_STAMP_HIGH: next_rdata = stamp_value[15:8];
				ADDR_ACCEPTANCE_MASK_FOUR: next_rdata = acceptance_mask_four;
				default: next_rdata = READ_IDLE;
			endcase
		end
	end

	assign next_tx_byte = mailbox_byte[{TX_BYTE_PAGE_I, TX_BYTE_INDEX_I}];

	always_ff @(posedge CLK_I)
	begin
		if (!RST_N_I)
		begin
			timer_prescaler <= PRESCALER_RESET;
			presc_count <= PRESCALER_RESET;
			message_timer_value <= TIMER_RESET;
			time_trigger_count <= TIMER_RESET;
		end
		else
		begin
			timer_prescaler <= next_timer_prescaler;
			presc_count <= next_presc_count;
			message_timer_value <= next_message_timer_value;
			time_trigger_count <= next_time_trigger_count;
		end
	end

	always_ff @(posedge CLK_I)
	begin
		if (!RST_N_I)
		begin
			byte_index <= '0;
		end
		else
		begin
			byte_index <= next_byte_index;
		end
	end

	always_ff @(posedge CLK_I)
	begin
		if (!RST_N_I)
		begin
			rdata <= READ_IDLE;
		end
		else
		begin
			rdata <= next_rdata;
		end
	end

	always_ff @(posedge CLK_I)
	begin
		if (!RST_N_I)
		begin
			match_valid <= 1'b0;
			match <= 1'b0;
		end
		else
		begin
			match_valid <= next_match_valid;
			match <= next_match;
		end
	end

	always_ff @(posedge CLK_I)
	begin
		if (!RST_N_I)
		begin
			tx_byte <= '0;
		end
		else
		begin
			tx_byte <= next_tx_byte;
		end
	end

	assign SFR_RDATA_O = rdata;
	assign INDEX_O = byte_index;
	assign RX_MATCH_VALID_O = match_valid;
	assign RX_MATCH_O = match;
	assign TX_BYTE_O = tx_byte;
endmodule

// File: verification/cmdt_regs_props.sv
// Checker for the mask, data window and timer register slice.
// Sees only the top module's ports; bound to every instance below.
`timescale 1ns/100ps
module cmdt_regs_props
	import cmdt_pkg::*;
(
	input wire logic CLK_I,
	input wire logic RST_N_I,
	input wire logic [7:0] SFR_ADDR_I,
	input wire logic SFR_WR_I,
	input wire logic SFR_RD_I,
	input wire logic [7:0] SFR_RDATA_O,
	input wire logic [BYTE_W-1:0] INDEX_I,
	input wire logic INDEX_LOAD_I,
	input wire logic AUTOINC_I,
	input wire logic [BYTE_W-1:0] INDEX_O,
	input wire logic RX_CHECK_I,
	input wire logic TX_ACTIVE_I,
	input wire logic RX_MATCH_VALID_O,
	input wire logic RX_MATCH_O,
	input wire logic RX_BYTE_VALID_I,
	input wire logic RX_BYTE_READY_O
);
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!RST_N_I);
	logic acc;
	assign acc = (SFR_RD_I || SFR_WR_I) && SFR_ADDR_I == ADDR_MESSAGE_DATA_WINDOW;
	AST_MATCH_PULSE: assert property (RX_CHECK_I && !TX_ACTIVE_I |=> RX_MATCH_VALID_O)
		else $error("match pulse missing");
	AST_TX_SILENT: assert property (!(RX_CHECK_I && !TX_ACTIVE_I) |=> !RX_MATCH_VALID_O)
		else $error("match pulse without check");
	AST_MATCH_HOLD: assert property (!RX_MATCH_VALID_O |-> $stable(RX_MATCH_O))
		else $error("match result moved");
	AST_PTR_STEP: assert property (acc && AUTOINC_I && !INDEX_LOAD_I
		|=> INDEX_O == $past(INDEX_O) + 3'd1) else $error("pointer did not step");
	AST_PTR_KEEP: assert property (!INDEX_LOAD_I && !(acc && AUTOINC_I) |=> $stable(INDEX_O))
		else $error("pointer moved");
	AST_PTR_LOAD: assert property (INDEX_LOAD_I |=> INDEX_O == $past(INDEX_I))
		else $error("pointer not loaded");
	AST_RD_HOLD: assert property (!SFR_RD_I |=> $stable(SFR_RDATA_O))
		else $error("read data moved");
	AST_MASK_RSVD: assert property (SFR_RD_I && SFR_ADDR_I == ADDR_ACCEPTANCE_MASK_FOUR
		|=> !SFR_RDATA_O[1]) else $error("reserved mask bit read high");
	AST_FULL_CAUSE: assert property ($fell(RX_BYTE_READY_O) |-> $past(RX_BYTE_VALID_I))
		else $error("buffer filled without push");
endmodule
bind cmdt_regs cmdt_regs_props u_props (.CLK_I(CLK_I), .RST_N_I(RST_N_I),
	.SFR_ADDR_I(SFR_ADDR_I), .SFR_WR_I(SFR_WR_I), .SFR_RD_I(SFR_RD_I),
	.SFR_RDATA_O(SFR_RDATA_O), .INDEX_I(INDEX_I), .INDEX_LOAD_I(INDEX_LOAD_I),
	.AUTOINC_I(AUTOINC_I), .INDEX_O(INDEX_O), .RX_CHECK_I(RX_CHECK_I),
	.TX_ACTIVE_I(TX_ACTIVE_I), .RX_MATCH_VALID_O(RX_MATCH_VALID_O),
	.RX_MATCH_O(RX_MATCH_O), .RX_BYTE_VALID_I(RX_BYTE_VALID_I),
	.RX_BYTE_READY_O(RX_BYTE_READY_O));

// File: verification/cmdt_node_model.sv
// Far-side node: hands received bytes to the slice on the valid/ready stream.
// Assumes the bench calls its tasks at a falling edge of the clock.
`timescale 1ns/100ps
module cmdt_node_model
	import cmdt_pkg::*;
(
	input wire logic clk_i,
	input wire logic ready_i,
	output logic valid_o = 1'b0,
	output logic [PAGE_W-1:0] page_o = '0,
	output logic [BYTE_W-1:0] index_o = '0,
	output logic [DATA_W-1:0] data_o = '0,
	output logic hung_o = 1'b0,
	output int stall_o = 0
);
	// Holds the beat until accepted; does not drop valid so sends can run back to back
	task send(input logic [PAGE_W-1:0] p, input logic [BYTE_W-1:0] i, input logic [7:0] d);
		int n;
		n = 0;
		valid_o = 1'b1;
		page_o = p;
		index_o = i;
		data_o = d;
		while (!ready_i && n < 40)
		begin
			stall_o++;
			n++;
			@(negedge clk_i);
		end
		if (n == 40)
			hung_o = 1'b1;
		@(negedge clk_i);
	endtask
	// A released line shows no stale byte
	task idle;
		valid_o = 1'b0;
		data_o = ~data_o;
	endtask
endmodule

// File: verification/cmdt_regs_test.sv
// Bench for the mask, data window and timer register slice.
// Assumes the design, the checker and the node model are compiled before it.
`timescale 1ns/100ps
module cmdt_regs_test
	import cmdt_pkg::*;
;
	logic clk = 0, rst_n = 0, wr = 0, rd = 0, ld = 0, ai = 0, tick = 0, stamp = 0;
	logic ttc = 0, chk_en = 0, txa = 0, hung, nv;
	logic [7:0] addr = 0, wd = 0, rdata, txb, nd;
	logic [1:0] page = 0, txp = 0, np;
	logic [2:0] idx = 0, txi = 0, index_o, ni;
	logic [6:0] rx = 0;
	logic mv, m, rdy;
	int err_total = 0, n_tests = 0, stalls;
	logic [7:0] mk [8] = '{8'h00, 8'hF8, 8'hF8, 8'h04, 8'h01, 8'hFD, 8'h08, 8'hF0};
	logic [6:0] rv [8] = '{7'h29, 7'h52, 7'h55, 7'h54, 7'h57, 7'h56, 7'h52, 7'h52};
	logic [6:0] tag = 7'h56;
	logic [7:0] ra [6] = '{8'hA1, 8'hA4, 8'hA5, 8'hAC, 8'hAD, 8'hA0};
	always #5 clk = ~clk;
	cmdt_regs dut (.CLK_I(clk), .RST_N_I(rst_n), .SFR_ADDR_I(addr), .SFR_WR_I(wr),
		.SFR_RD_I(rd), .SFR_WDATA_I(wd), .SFR_RDATA_O(rdata), .PAGE_I(page),
		.INDEX_I(idx), .INDEX_LOAD_I(ld), .AUTOINC_I(ai), .INDEX_O(index_o),
		.BASE_TICK_I(tick), .STAMP_CAPTURE_I(stamp), .TTC_SYNC_I(ttc),
		.RX_CHECK_I(chk_en), .TX_ACTIVE_I(txa), .RX_IDENT_I(rx[6:2]),
		.RX_REMOTE_I(rx[1]), .RX_EXT_I(rx[0]), .TAG_IDENT_I(tag[6:2]),
		.TAG_REMOTE_I(tag[1]), .TAG_EXT_I(tag[0]), .RX_MATCH_VALID_O(mv),
		.RX_MATCH_O(m), .RX_BYTE_VALID_I(nv), .RX_BYTE_READY_O(rdy),
		.RX_BYTE_PAGE_I(np), .RX_BYTE_INDEX_I(ni), .RX_BYTE_I(nd),
		.TX_BYTE_PAGE_I(txp), .TX_BYTE_INDEX_I(txi), .TX_BYTE_O(txb));
	cmdt_node_model node (.clk_i(clk), .ready_i(rdy), .valid_o(nv), .page_o(np),
		.index_o(ni), .data_o(nd), .hung_o(hung), .stall_o(stalls));
	task end_of_test;
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			err_total++;
			$display("unexpected %s: expected %h seen %h", nm, exp, seen);
		end
	endtask
	task wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		addr = a;
		wd = d;
		wr = 1;
		@(negedge clk);
		wr = 0;
	endtask
	task rd_reg(input logic [7:0] a, input logic [7:0] exp);
		@(negedge clk);
		addr = a;
		rd = 1;
		@(negedge clk);
		rd = 0;
		chk("read data", rdata, exp);
	endtask
	task load(input logic [1:0] p, input logic [2:0] i);
		@(negedge clk);
		page = p;
		idx = i;
		ld = 1;
		@(negedge clk);
		ld = 0;
	endtask
	// Masks never set bit 1, as software must not
	task acc(input logic [7:0] mask, input logic [6:0] r, input logic tx);
		logic [6:0] en;
		en = {mask[7:3], mask[2], mask[0]};
		wr_reg(ADDR_ACCEPTANCE_MASK_FOUR, mask);
		rx = r;
		txa = tx;
		chk_en = 1;
		@(negedge clk);
		chk_en = 0;
		txa = 0;
		chk("match valid", {7'd0, mv}, {7'd0, !tx});
		if (!tx)
			chk("match", {7'd0, m}, {7'd0, ((r ^ tag) & en) == 7'd0});
	endtask
	always @(posedge hung)
	begin
		err_total++;
		end_of_test();
	end
	initial
	begin
		repeat (12) @(negedge clk);
		rst_n = 1;
		foreach (ra[k])
			rd_reg(ra[k], 8'h00);
		for (int k = 0; k < 8; k++)
			acc(mk[k], rv[k], 0);
		acc(8'hFD, 7'h29, 1);
		// A second tag value so the compare is not tied to one constant
		tag = 7'h29;
		acc(8'hFD, 7'h29, 0);
		acc(8'hFD, 7'h2B, 0);
		rd_reg(ADDR_ACCEPTANCE_MASK_FOUR, 8'hFD);
		wr_reg(ADDR_TIMER_PRESCALER, 8'h02);
		rd_reg(ADDR_TIMER_PRESCALER, 8'h02);
		repeat (9)
		begin
			@(negedge clk);
			tick = 1;
			@(negedge clk);
			tick = 0;
		end
		wr_reg(ADDR_MESSAGE_TIMER_LOW, 8'hFF);
		rd_reg(ADDR_MESSAGE_TIMER_LOW, 8'h03);
		rd_reg(ADDR_MESSAGE_TIMER_HIGH, 8'h00);
		@(negedge clk);
		stamp = 1;
		ttc = 1;
		@(negedge clk);
		stamp = 0;
		ttc = 0;
		wr_reg(ADDR_TIME_STAMP_LOW, 8'h55);
		rd_reg(ADDR_TIME_STAMP_LOW, 8'h03);
		rd_reg(ADDR_TIME_STAMP_HIGH, 8'h00);
		rd_reg(ADDR_TIME_TRIGGER_LOW, 8'h03);
		rd_reg(ADDR_TIME_TRIGGER_HIGH, 8'h00);
		load(0, 6);
		ai = 1;
		wr_reg(ADDR_MESSAGE_DATA_WINDOW, 8'hA6);
		wr_reg(ADDR_MESSAGE_DATA_WINDOW, 8'hA7);
		chk("pointer", {5'd0, index_o}, 8'h00);
		load(0, 6);
		rd_reg(ADDR_MESSAGE_DATA_WINDOW, 8'hA6);
		rd_reg(ADDR_MESSAGE_DATA_WINDOW, 8'hA7);
		txi = 7;
		@(negedge clk);
		chk("tx byte", txb, 8'hA7);
		// CPU writes every cycle so the buffer cannot drain and must refuse
		ai = 0;
		load(3, 0);
		fork
			begin
				@(negedge clk);
				addr = ADDR_MESSAGE_DATA_WINDOW;
				wd = 8'h33;
				wr = 1;
				repeat (14) @(negedge clk);
				wr = 0;
			end
			begin
				for (int k = 0; k < 9; k++)
					node.send(k < 8 ? 2'd1 : 2'd2, 3'(k), 8'h40 + 8'(k));
				node.idle();
			end
		join
		chk("refused", {7'd0, stalls > 0}, 8'h01);
		// Buffer drains one byte a cycle
		repeat (9) @(negedge clk);
		load(1, 0);
		ai = 1;
		for (int k = 0; k < 9; k++)
			rd_reg(ADDR_MESSAGE_DATA_WINDOW, k < 8 ? 8'h40 + 8'(k) : 8'h40);
		load(2, 0);
		rd_reg(ADDR_MESSAGE_DATA_WINDOW, 8'h48);
		load(3, 0);
		rd_reg(ADDR_MESSAGE_DATA_WINDOW, 8'h33);
		end_of_test();
	end
endmodule
